// File: logic/tec_map.svh
// Purpose: register offsets, field positions and reset values of the timer
// Assumes: 8-bit register port, byte-wide registers
// Notes:   definitions only
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define TEC_OFF_COUNT 8'h0D
`define TEC_OFF_CTRL  8'h0E
`define TEC_OFF_INTC  8'h0B

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define TEC_CTRL_ZERO_BIT 5
`define TEC_INTC_FLAG_BIT 5
`define TEC_INTC_EN_BIT   0
`define TEC_CTRL_RUN_BIT  4

// ----------------------------------------------------------------------
// reset values and constants
// ----------------------------------------------------------------------
`define TEC_CTRL_RST  8'h08
`define TEC_INTC_RST  8'h00
`define TEC_COUNT_RST 8'h00
`define TEC_PSC_RST   7'h00
`define TEC_PSC_ONE   7'h01
`define TEC_PSC_DIV1  3'h0
`define TEC_COUNT_MAX 8'hFF
`define TEC_COUNT_ONE 8'h01
`define TEC_ZERO8     8'h00

`endif

// File: logic/tec_pkg.sv
// Purpose: types shared by the timer/event counter
// Assumes: nothing
// Notes:   field layout of the control register is the struct order
package tec_pkg;

  typedef enum logic [1:0] {
    TEC_MODE_NONE   = 2'h0,
    TEC_MODE_EVENT  = 2'h1,
    TEC_MODE_TIMER  = 2'h2,
    TEC_MODE_PWIDTH = 2'h3
  } tec_mode_t;

  typedef enum logic [2:0] {
    TEC_PW_IDLE  = 3'h1,
    TEC_PW_ARMED = 3'h2,
    TEC_PW_MEAS  = 3'h4
  } tec_pw_state_t;

  typedef struct packed {
    tec_mode_t  mode;
    logic       unused;
    logic       countRun;
    logic       edgeSelect;
    logic [2:0] prescaleSelect;
  } tec_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStb;
    logic       rdStb;
  } tec_bus_t;

endpackage : tec_pkg

// File: logic/tec_timer_event_counter.sv
// Purpose: 8-bit count-up timer / event counter with preload and pulse width mode
// Assumes: pin and bus inputs synchronous to clk; rd and wr strobes never together
// Notes:   read data valid only in the cycle after the read strobe
`timescale 1ns/1ns
`include "tec_map.svh"

// Notes on behaviour
// R1: eight-bit up counter, pin or internal clock
// R2: write sets preload, read returns live count
// R3: control bits 7:6 select the mode
// R4: at FFH overflow reload and set flag
// R5: event mode counts active pin edges
// R6: timer mode counts prescaled internal clock
// R7: pulse mode counts until pin level returns
// R8: one measurement per software run set
// R9: pulse counting starts on an edge only
// R10: pulse mode overflow reloads and flags too
// R11: control bit 4 enables counting
// R12: run bit kept in event and timer modes
// R13: overflow gives a wake-up pulse
// R14: enable bit zero suppresses overflow interrupt
// R15: write while stopped also loads counter
// R16: write while running loads preload only
// R17: count clock blocked during counter read
// R18: bits 2:0 divide clock by power of two
// R19: bit 3 picks rising or falling edge
// R20: control bit 5 reads as zero
// R21: unused mode code holds the counter
module tec_timer_event_counter
  import tec_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire tec_bus_t   busReq,
  output logic      [7:0] rdData,
  input  wire logic       timerInputPin,
  output logic            overflowIrq,
  output logic            wakeUp
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [7:0]    count;
  logic [7:0]    preload;
  tec_ctrl_t     ctrl;
  logic          overflowFlag;
  logic          overflowIrqEnable;
  logic [6:0]    prescaler;
  logic          pinPrev;
  tec_pw_state_t pwState;

  logic [7:0]    next_count;
  logic [7:0]    next_preload;
  tec_ctrl_t     next_ctrl;
  logic          next_overflowFlag;
  logic          next_overflowIrqEnable;
  logic [6:0]    next_prescaler;
  logic          next_pinPrev;
  tec_pw_state_t next_pwState;
  logic [7:0]    next_rdData;
  logic          next_wakeUp;

  // ----------------------------------------------------------------------
  // decode and count clock
  // ----------------------------------------------------------------------
  logic       wrCount;
  logic       wrCtrl;
  logic       wrIntc;
  logic       rdCount;
  logic [6:0] pscMask;
  logic       fintTick;
  logic       activeEdge;
  logic       returnEdge;
  logic       countTick;
  logic       overflow;
  logic       pwDone;

  assign wrCount = busReq.wrStb && (busReq.addr == `TEC_OFF_COUNT);
  assign wrCtrl  = busReq.wrStb && (busReq.addr == `TEC_OFF_CTRL);
  assign wrIntc  = busReq.wrStb && (busReq.addr == `TEC_OFF_INTC);
  assign rdCount = busReq.rdStb && (busReq.addr == `TEC_OFF_COUNT);

  // one tick every 2^psc cycles from a free-running divider
  // mask bit i is set when the select asks for more than i divider stages
  for (genvar pscBit = 0; pscBit < $bits(pscMask); pscBit++) begin : g_psc_mask
    assign pscMask[pscBit] = (ctrl.prescaleSelect > 3'(pscBit)); // R18
  end
  assign fintTick = (prescaler & pscMask) == pscMask;           // R18

  // a level already present when enabled starts nothing; only transitions count
  assign activeEdge = ctrl.edgeSelect ? (pinPrev & ~timerInputPin)
                                      : (~pinPrev & timerInputPin); // R19 R9
  assign returnEdge = ctrl.edgeSelect ? (~pinPrev & timerInputPin)
                                      : (pinPrev & ~timerInputPin); // R7

  // reading the count blocks the tick; a lost tick is the price of clean data
  always_comb begin
    countTick = 1'b0;
    case (ctrl.mode) // R3
      TEC_MODE_EVENT:  countTick = activeEdge;                      // R5
      TEC_MODE_TIMER:  countTick = fintTick;                        // R6
      TEC_MODE_PWIDTH: countTick = (pwState == TEC_PW_MEAS) && fintTick
                                   && !returnEdge;                  // R7
      TEC_MODE_NONE:   countTick = 1'b0;                            // R21
      default:         countTick = 1'b0;
    endcase
    countTick = countTick && ctrl.countRun && !rdCount;             // R11 R17 R1
  end

  assign overflow = countTick && (count == `TEC_COUNT_MAX);
  assign pwDone   = (ctrl.mode == TEC_MODE_PWIDTH) && (pwState == TEC_PW_MEAS)
                    && returnEdge;

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  // free-running divider and pin history
  always_comb begin
    next_prescaler = prescaler + `TEC_PSC_ONE;
    next_pinPrev   = timerInputPin;
  end

  // counter and preload
  always_comb begin
    next_count   = count;
    next_preload = preload;
    if (wrCount) begin
      next_preload = busReq.wrData;                                 // R2 R16
      if (!ctrl.countRun) begin
        next_count = busReq.wrData;                                 // R15
      end
    end
    if (overflow) begin
      next_count = preload;                                         // R4 R10
    end else if (countTick) begin
      next_count = count + `TEC_COUNT_ONE;                          // R1
    end
  end

  // pulse width one-shot sequence
  always_comb begin
    next_pwState = pwState;
    case (pwState)
      TEC_PW_IDLE: begin
        if (ctrl.mode == TEC_MODE_PWIDTH && ctrl.countRun) begin
          next_pwState = TEC_PW_ARMED;
        end
      end
      TEC_PW_ARMED: begin
        if (ctrl.mode != TEC_MODE_PWIDTH || !ctrl.countRun) begin
          next_pwState = TEC_PW_IDLE;
        end else if (activeEdge) begin
          next_pwState = TEC_PW_MEAS;                               // R9
        end
      end
      TEC_PW_MEAS: begin
        if (ctrl.mode != TEC_MODE_PWIDTH || !ctrl.countRun || returnEdge) begin
          next_pwState = TEC_PW_IDLE;                               // R8
        end
      end
      default: next_pwState = TEC_PW_IDLE;
    endcase
  end

  // control: hardware clears run only on pulse completion
  always_comb begin
    next_ctrl = ctrl;
    if (pwDone) begin
      next_ctrl.countRun = 1'b0;                                    // R7 R12
    end
    if (wrCtrl) begin
      next_ctrl        = tec_ctrl_t'(busReq.wrData);                // R3 R11 R19
      next_ctrl.unused = 1'b0;                                      // R20
    end
  end

  // interrupt control: hardware set beats software clear
  always_comb begin
    next_overflowIrqEnable = overflowIrqEnable;
    next_overflowFlag      = overflowFlag;
    if (wrIntc) begin
      next_overflowIrqEnable = busReq.wrData[`TEC_INTC_EN_BIT];
      next_overflowFlag      = busReq.wrData[`TEC_INTC_FLAG_BIT];
    end
    if (overflow) begin
      next_overflowFlag = 1'b1;                                     // R4
    end
  end

  // read port and wake-up pulse
  always_comb begin
    next_wakeUp = overflow;                                         // R13
    next_rdData = `TEC_ZERO8;
    if (busReq.rdStb) begin
      case (busReq.addr)
        `TEC_OFF_COUNT: next_rdData = count;                        // R2
        `TEC_OFF_CTRL: begin
          next_rdData                     = ctrl;
          next_rdData[`TEC_CTRL_ZERO_BIT] = 1'b0;                   // R20
        end
        `TEC_OFF_INTC: begin
          next_rdData                     = `TEC_ZERO8;
          next_rdData[`TEC_INTC_FLAG_BIT] = overflowFlag;
          next_rdData[`TEC_INTC_EN_BIT]   = overflowIrqEnable;
        end
        default: next_rdData = `TEC_ZERO8;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      prescaler <= `TEC_PSC_RST;
      pinPrev   <= 1'b0;
    end else begin
      prescaler <= next_prescaler;
      pinPrev   <= next_pinPrev;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count   <= `TEC_COUNT_RST;
      preload <= `TEC_COUNT_RST;
    end else begin
      count   <= next_count;
      preload <= next_preload;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pwState <= TEC_PW_IDLE;
    end else begin
      pwState <= next_pwState;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= tec_ctrl_t'(`TEC_CTRL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      overflowFlag      <= 1'b0;
      overflowIrqEnable <= 1'b0;
    end else begin
      overflowFlag      <= next_overflowFlag;
      overflowIrqEnable <= next_overflowIrqEnable;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= `TEC_ZERO8;
      wakeUp <= 1'b0;
    end else begin
      rdData <= next_rdData;
      wakeUp <= next_wakeUp;
    end
  end

  // software masks service, the flag itself still records the event
  assign overflowIrq = overflowFlag && overflowIrqEnable;          // R14

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_ovf_reload: // R4
    assert property (overflow |=> (count == $past(preload)) && overflowFlag)
      else $error("overflow did not reload and flag");
  a_flag_set_wins: // R4
    assert property (overflow && wrIntc |=> overflowFlag)
      else $error("software clear beat overflow set");
  a_pw_ovf: // R10
    assert property (overflow && ctrl.mode == TEC_MODE_PWIDTH |=> overflowFlag)
      else $error("pulse mode overflow not flagged");
  a_wake_pulse: // R13
    assert property (overflow |=> wakeUp ##1 !wakeUp || $past(overflow))
      else $error("wake-up pulse missing");
  a_irq_gate: // R14
    assert property (wrIntc && !busReq.wrData[`TEC_INTC_EN_BIT] |=> !overflowIrq)
      else $error("interrupt not suppressed");
  a_stop_load: // R15
    assert property (wrCount && !ctrl.countRun |=> count == $past(busReq.wrData))
      else $error("stopped write did not load counter");
  a_run_load: // R16
    assert property (wrCount && ctrl.countRun && !countTick
                     |=> count == $past(count))
      else $error("running write disturbed counter");
  a_read_gate: // R17
    assert property (rdCount |=> count == $past(count))
      else $error("counter moved during read");
  a_read_value: // R2
    assert property (rdCount |=> rdData == $past(count))
      else $error("read returned wrong count");
  a_zero_bit: // R20
    assert property (busReq.rdStb && busReq.addr == `TEC_OFF_CTRL
                     |=> !rdData[`TEC_CTRL_ZERO_BIT])
      else $error("unused control bit read as one");
  a_unused_mode: // R21
    assert property (ctrl.mode == TEC_MODE_NONE && !wrCount
                     |=> count == $past(count) && !wakeUp)
      else $error("unused mode moved counter");
  a_event_edge: // R5
    assert property (ctrl.mode == TEC_MODE_EVENT && ctrl.countRun && activeEdge
                     && !rdCount && !wrCount && count != `TEC_COUNT_MAX
                     |=> count == $past(count) + `TEC_COUNT_ONE)
      else $error("event edge not counted");
  a_timer_idle: // R6
    assert property (ctrl.mode == TEC_MODE_TIMER && !fintTick && !wrCount
                     |=> $stable(count))
      else $error("timer counted without tick");
  a_pw_stop: // R7
    assert property (pwDone && !wrCtrl |=> !ctrl.countRun ##1 pwState == TEC_PW_IDLE)
      else $error("pulse end did not stop and clear run");
  a_pw_level: // R9
    assert property (pwState == TEC_PW_ARMED && !wrCount |=> $stable(count))
      else $error("counted before start edge");
  a_run_hold: // R12
    assert property (ctrl.mode != TEC_MODE_PWIDTH && ctrl.countRun && !wrCtrl
                     |=> ctrl.countRun)
      else $error("run bit cleared by itself");
  a_tick_step: // R1
    assert property (countTick && count != `TEC_COUNT_MAX
                     |=> count == $past(count) + `TEC_COUNT_ONE)
      else $error("tick did not advance counter by one");
  a_psc_period: // R18
    assert property (fintTick && ctrl.prescaleSelect != `TEC_PSC_DIV1 && !wrCtrl
                     |=> !fintTick)
      else $error("divided tick repeated in next cycle");
  a_wrong_edge: // R5
    assert property (ctrl.mode == TEC_MODE_EVENT && !activeEdge && !wrCount
                     |=> $stable(count))
      else $error("event counter moved without active edge");
  a_pw_single: // R8
    assert property (ctrl.mode == TEC_MODE_PWIDTH && !ctrl.countRun && !wrCount
                     |=> $stable(count))
      else $error("pulse count moved after measurement");
  a_pw_start: // R9
    assert property (pwState == TEC_PW_ARMED && activeEdge && ctrl.countRun
                     && ctrl.mode == TEC_MODE_PWIDTH |=> pwState == TEC_PW_MEAS)
      else $error("start edge did not begin measurement");
  a_wr_preload: // R2
    assert property (wrCount |=> preload == $past(busReq.wrData))
      else $error("write did not reach preload");
  a_read_idle: // R2
    assert property (!busReq.rdStb |=> rdData == `TEC_ZERO8)
      else $error("read data not zero outside read");
  a_run_write: // R11
    assert property (wrCtrl |=> ctrl.countRun == $past(busReq.wrData[`TEC_CTRL_RUN_BIT]))
      else $error("run bit not taken from write");

  // ----------------------------------------------------------------------
  // cover points
  // ----------------------------------------------------------------------

  c_timer_ovf:
    cover property (ctrl.mode == TEC_MODE_TIMER && overflow);
  c_pw_done:
    cover property (pwState == TEC_PW_MEAS ##[1:300] pwDone);
  c_event_count:
    cover property (ctrl.mode == TEC_MODE_EVENT && countTick);
  c_pw_overflow:
    cover property (ctrl.mode == TEC_MODE_PWIDTH && overflow);
  c_read_block:
    cover property (rdCount && ctrl.countRun && ctrl.mode == TEC_MODE_TIMER);

endmodule : tec_timer_event_counter

// File: verif/tec_pin_src.sv
// Purpose: far-side source of the timer input pin
// Assumes: pin idles low, synchronous to clk
// Notes:   one pulse per go request, high for len cycles
`timescale 1ns/1ns
module tec_pin_src (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       go,
  input  wire logic [7:0] len,
  output logic            pin
);
  logic [7:0] left;

  always_ff @(posedge clk) begin
    if (rst) begin
      left <= 8'h00;
      pin  <= 1'b0;
    end else if (go) begin
      left <= len;
      pin  <= 1'b1;
    end else if (left > 8'h01) begin
      left <= left - 8'h01;
    end else begin
      left <= 8'h00;
      pin  <= 1'b0;
    end
  end
endmodule : tec_pin_src

// File: verif/tb_top.sv
// Purpose: self-checking bench of the timer/event counter
// Assumes: pin source model on the timer input
// Notes:   waits are bounded; a hang ends the run as a failure
`timescale 1ns/1ns
`include "tec_map.svh"
module tb_top
  import tec_pkg::*;
;
  logic       clk;
  logic       rst;
  tec_bus_t   busReq;
  logic [7:0] rdData;
  logic       pin;
  logic       overflowIrq;
  logic       wakeUp;
  logic       go;
  logic [7:0] pulseLen;
  int         badCount;
  int         totalChecks;
  int         wakeCount = 0;

  tec_timer_event_counter dut (.clk(clk), .rst(rst), .busReq(busReq), .rdData(rdData),
    .timerInputPin(pin), .overflowIrq(overflowIrq), .wakeUp(wakeUp));
  tec_pin_src src (.clk(clk), .rst(rst), .go(go), .len(pulseLen), .pin(pin));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) if (wakeUp === 1'b1) wakeCount <= wakeCount + 1;

  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic complete_run();
    if (badCount == 0 && totalChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    busReq <= '{addr: a, wrData: d, wrStb: 1'b1, rdStb: 1'b0};
    @(posedge clk);
    busReq <= '0;
    @(posedge clk);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    busReq <= '{addr: a, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge clk);
    busReq <= '0;
    @(negedge clk) d = rdData;
    @(posedge clk);
  endtask : rd

  task automatic pulse(input logic [7:0] len);
    go       <= 1'b1;
    pulseLen <= len;
    @(posedge clk);
    go <= 1'b0;
  endtask : pulse

  task automatic restart(input logic [7:0] ctrl);
    wr(`TEC_OFF_CTRL, 8'h00);
    wr(`TEC_OFF_COUNT, 8'h00);
    wr(`TEC_OFF_CTRL, ctrl);
  endtask : restart

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic regs_and_hold();
    logic [7:0] v;
    rd(`TEC_OFF_CTRL, v);
    check(v, `TEC_CTRL_RST);
    rd(`TEC_OFF_INTC, v);
    check(v, 8'h00);
    wr(8'h40, 8'hFF);
    rd(8'h40, v);
    check(v, 8'h00);
    wr(`TEC_OFF_COUNT, 8'h5A);
    rd(`TEC_OFF_COUNT, v);
    check(v, 8'h5A);
    wr(`TEC_OFF_CTRL, 8'h38);
    rd(`TEC_OFF_CTRL, v);
    check(v, 8'h18);
    repeat (20) @(posedge clk);
    rd(`TEC_OFF_COUNT, v);
    check(v, 8'h5A);
  endtask : regs_and_hold

  // run stays high exactly 4 << n cycles, so four ticks are expected
  task automatic prescale_rates();
    logic [7:0] v;
    for (int n = 0; n < 8; n++) begin
      restart({5'h12, n[2:0]});
      repeat ((4 << n) - 2) @(posedge clk);
      wr(`TEC_OFF_CTRL, 8'h00);
      rd(`TEC_OFF_COUNT, v);
      check(v, 8'h04);
    end
  endtask : prescale_rates

  task automatic read_gate();
    logic [7:0] v;
    logic [7:0] w;
    restart(8'h90);
    repeat (3) @(posedge clk);
    busReq <= '{addr: `TEC_OFF_COUNT, wrData: 8'h00, wrStb: 1'b0, rdStb: 1'b1};
    @(posedge clk);
    @(negedge clk) v = rdData;
    @(posedge clk);
    busReq <= '0;
    @(negedge clk) w = rdData;
    check(w, v);
    @(posedge clk);
    rd(`TEC_OFF_COUNT, w);
    check(w, v + 8'h01);
  endtask : read_gate

  task automatic timer_overflow();
    logic [7:0] v;
    int         n;
    wr(`TEC_OFF_CTRL, 8'h00);
    wr(`TEC_OFF_COUNT, 8'hFE);
    wr(`TEC_OFF_INTC, 8'h01);
    n = wakeCount;
    wr(`TEC_OFF_CTRL, 8'h97);
    wr(`TEC_OFF_COUNT, 8'h10);
    rd(`TEC_OFF_COUNT, v);
    check({7'h00, v === 8'hFE || v === 8'hFF}, 8'h01);
    for (int i = 0; i < 600 && overflowIrq !== 1'b1; i++) @(negedge clk);
    if (overflowIrq !== 1'b1) begin
      badCount++;
      complete_run();
    end
    @(posedge clk);
    rd(`TEC_OFF_COUNT, v);
    check(v, 8'h10);
    check(8'(wakeCount - n), 8'h01);
    rd(`TEC_OFF_INTC, v);
    check(v, 8'h21);
    rd(`TEC_OFF_CTRL, v);
    check(v, 8'h97);
    wr(`TEC_OFF_INTC, 8'h20);
    @(negedge clk);
    check({7'h00, overflowIrq}, 8'h00);
    @(posedge clk);
    wr(`TEC_OFF_INTC, 8'h00);
  endtask : timer_overflow

  task automatic event_edges();
    logic [7:0] v;
    for (int e = 0; e < 2; e++) begin
      restart({4'h5, e[0], 3'h0});
      pulse(8'h1E);
      repeat (10) @(posedge clk);
      rd(`TEC_OFF_COUNT, v);
      check(v, {7'h00, ~e[0]});
      repeat (30) @(posedge clk);
      rd(`TEC_OFF_COUNT, v);
      check(v, 8'h01);
    end
  endtask : event_edges

  // pin already high at enable, so only the later rising edge may start it
  task automatic pulse_width();
    logic [7:0] v;
    logic [7:0] w;
    wr(`TEC_OFF_CTRL, 8'h00);
    wr(`TEC_OFF_COUNT, 8'h00);
    pulse(8'h3C);
    repeat (5) @(posedge clk);
    wr(`TEC_OFF_CTRL, 8'hD0);
    repeat (70) @(posedge clk);
    rd(`TEC_OFF_COUNT, v);
    check(v, 8'h00);
    pulse(8'h14);
    repeat (30) @(posedge clk);
    rd(`TEC_OFF_COUNT, v);
    check({7'h00, v >= 8'h13 && v <= 8'h15}, 8'h01);
    rd(`TEC_OFF_CTRL, w);
    check(w, 8'hC0);
    pulse(8'h14);
    repeat (30) @(posedge clk);
    rd(`TEC_OFF_COUNT, w);
    check(w, v);
    wr(`TEC_OFF_COUNT, 8'hF0);
    wr(`TEC_OFF_CTRL, 8'hD0);
    pulse(8'h14);
    repeat (30) @(posedge clk);
    rd(`TEC_OFF_COUNT, v);
    check({7'h00, v >= 8'hF2 && v <= 8'hF4}, 8'h01);
    rd(`TEC_OFF_INTC, w);
    check(w, 8'h20);
  endtask : pulse_width

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    busReq      = '0;
    rst         = 1'b1;
    go          = 1'b0;
    pulseLen    = 8'h00;
    badCount    = 0;
    totalChecks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    regs_and_hold();
    prescale_rates();
    read_gate();
    timer_overflow();
    event_edges();
    pulse_width();
    complete_run();
  end
endmodule : tb_top
